// ---- hw/reset_source_sequencer.sv ----
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/10ps
module reset_source_sequencer
  import rst_seq_pkg::*;
#(
  parameter int WD_EXP = WD_INT_EXP,
  parameter int WD_CNT_W = WD_COUNT_W,
  parameter int HOLD = RESET_HOLD_CYCLES
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic POR_RISE_I,
  input wire logic DEBUG_MODE_I,
  input wire logic RESET_N_PIN_I,
  output logic RESET_N_PIN_O,
  output logic RESET_N_PIN_OE_O,
  output logic CPU_HALT_O,
  output logic SYS_RESET_O,
  output logic POR_RESET_O,
  output logic PC_LOAD_O,
  output logic [REG_W-1:0] PC_VECTOR_O,
  output logic RC_OSC_EN_O,
  output logic CLK_SEL_RC_O,
  output logic IRQ_O,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [DATA_W-1:0] WB_DAT_I,
  output logic [DATA_W-1:0] WB_DAT_O,
  output logic WB_ACK_O
);

  function automatic logic [REG_W-1:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [REG_W-1:0] merge16(
    input logic [REG_W-1:0] old_val,
    input logic [REG_W-1:0] new_val,
    input logic [3:0] sel
  );
    logic [REG_W-1:0] m;
    m = lane_mask(sel);
    merge16 = (old_val & ~m) | (new_val & m);
  endfunction

  wb_req_t bus;
  reset_src_t src;
  seq_state_t state;
  seq_state_t next_state;

  logic rs_active;
  logic rs_internal;
  logic rs_por;
  logic ext_prev;
  logic por_clr;
  logic sys_clr;

  logic [1:0] wd_period;
  logic wd_enable;
  logic wd_int_flag;
  logic wd_rst_flag;
  logic power_loss;
  logic wd_int_pulse;
  logic wd_reset_pulse;

  logic [REG_W-1:0] osc_ctrl;
  logic [DBG_FIELD_W-1:0] dbg_rw;
  logic [DBG_FIELD_W-1:0] dbg_wo;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_set;

  assign bus = {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I};

  // Bus decode. A write lands on the edge that also samples ack.
  wire req = bus.cyc & bus.stb;
  wire wr = req & bus.we & WB_ACK_O;
  wire hit_wdog = bus.adr == OFS_WDOG_CTRL;
  wire hit_osc = bus.adr == OFS_OSC_CTRL;
  wire hit_dbg = bus.adr == OFS_DEBUG;
  wire hit_stat = bus.adr == OFS_IRQ_STATUS;
  wire hit_mask = bus.adr == OFS_IRQ_MASK;
  wire hit_state = bus.adr == OFS_RESET_STATE;
  wire [REG_W-1:0] wdat = bus.dat[REG_W-1:0];
  wire [REG_W-1:0] wmask = lane_mask(bus.sel);
  wire [REG_W-1:0] w1 = wdat & wmask;

  wire wr_wdog = wr & hit_wdog;
  wire wr_osc = wr & hit_osc;
  wire wr_dbg = wr & hit_dbg & DEBUG_MODE_I;
  wire wr_stat = wr & hit_stat;
  wire wr_mask = wr & hit_mask;

  wire [REG_W-1:0] wdog_word = {8'h00, power_loss, wd_rst_flag, 1'b0,
    wd_int_flag, 1'b0, wd_enable, wd_period};
  wire [REG_W-1:0] wdog_new = merge16(wdog_word, wdat, bus.sel);
  wire wd_kick = wr_wdog & w1[WDC_KICK];
  wire wd_int_clr = wr_wdog & w1[WDC_INT_FLAG];
  wire wd_rst_clr = wr_wdog & w1[WDC_RST_FLAG];
  wire power_loss_clr = wr_wdog & w1[WDC_POWER_LOSS];

  wire [REG_W-1:0] mask_new = merge16({12'h000, irq_mask}, wdat, bus.sel);
  wire [REG_W-1:0] dbg_word = {dbg_rw, dbg_wo};
  wire [REG_W-1:0] dbg_new = merge16(dbg_word, wdat, bus.sel);
  // Outside debug mode the read/write field reads as zero.
  wire [REG_W-1:0] dbg_rd = {DEBUG_MODE_I ? dbg_rw : 8'h00, dbg_wo};

  wire [REG_W-1:0] state_word = {8'h00, 2'b00, state, rs_por, rs_internal,
    rs_active, src.ext};

  wire [REG_W-1:0] rd_word =
    hit_wdog ? wdog_word :
    hit_osc ? osc_ctrl :
    hit_dbg ? dbg_rd :
    hit_stat ? {12'h000, irq_status} :
    hit_mask ? {12'h000, irq_mask} :
    hit_state ? state_word : 16'h0000;

  // The pin reads back our own drive, so only an undriven low counts.
  // supply rise, watchdog pulse, undriven low pin.
  assign src = '{por: POR_RISE_I, wd: wd_reset_pulse,
    ext: ~RESET_N_PIN_I & ~RESET_N_PIN_OE_O};

  assign por_clr = RESET_I | rs_por;
  assign sys_clr = RESET_I | rs_active;

  assign irq_set[IRQ_WD_INT] = wd_int_pulse;
  assign irq_set[IRQ_WD_RESET] = wd_reset_pulse;
  assign irq_set[IRQ_EXT_RESET] = src.ext & ~ext_prev;
  assign irq_set[IRQ_POR] = rs_por;

  reset_stretch #(
    .HOLD(HOLD)
  ) u_stretch (
    .clk_i(CORE_CLK_I),
    .rst_i(RESET_I),
    .src_i(src),
    .active_o(rs_active),
    .internal_o(rs_internal),
    .por_o(rs_por)
  );

  // Any reset restores the default period and restarts the count.
  watchdog_timer #(
    .EXP(WD_EXP),
    .CNT_W(WD_CNT_W)
  ) u_wdog (
    .clk_i(CORE_CLK_I),
    .clear_i(sys_clr),
    .period_i(wd_period),
    .reset_en_i(wd_enable),
    .kick_i(wd_kick),
    .int_flag_i(wd_int_flag),
    .int_pulse_o(wd_int_pulse),
    .reset_pulse_o(wd_reset_pulse)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (rs_active) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!rs_active) begin
          next_state = ST_EXIT;
        end
      end
      ST_EXIT: begin
        next_state = rs_active ? ST_HOLD : ST_RUN;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      state <= ST_RUN;
      ext_prev <= 1'b0;
    end else begin
      state <= next_state;
      ext_prev <= src.ext;
    end
  end

  // Processor-facing outputs, all registered.
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      CPU_HALT_O <= 1'b1;
      SYS_RESET_O <= 1'b0;
      POR_RESET_O <= 1'b0;
      PC_LOAD_O <= 1'b0;
      PC_VECTOR_O <= RESET_VECTOR;
      RC_OSC_EN_O <= 1'b1;
      RESET_N_PIN_O <= 1'b0;
      RESET_N_PIN_OE_O <= 1'b0;
    end else begin
      CPU_HALT_O <= rs_active | (next_state != ST_RUN);
      SYS_RESET_O <= rs_active;
      POR_RESET_O <= rs_por;
      PC_LOAD_O <= next_state == ST_EXIT;
      PC_VECTOR_O <= RESET_VECTOR;
      // No reset source may stop the RC oscillator.
      RC_OSC_EN_O <= 1'b1;
      RESET_N_PIN_O <= 1'b0;
      RESET_N_PIN_OE_O <= rs_internal;
    end
  end

  // Watchdog control: period and enable return to default on any reset,
  // while the reset and power-loss flags survive all but power-on reset, so software can read them afterwards.
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      wd_period <= WD_PERIOD_RESET;
      wd_enable <= WD_ENABLE_RESET;
      wd_int_flag <= 1'b0;
      wd_rst_flag <= 1'b0;
      power_loss <= 1'b0;
    end else if (rs_por) begin
      wd_period <= WD_PERIOD_RESET;
      wd_enable <= WD_ENABLE_RESET;
      wd_int_flag <= 1'b0;
      wd_rst_flag <= 1'b0;
      power_loss <= 1'b1;
    end else begin
      if (rs_active) begin
        wd_period <= WD_PERIOD_RESET;
        wd_enable <= WD_ENABLE_RESET;
      end else if (wr_wdog) begin
        wd_period <= wdog_new[WDC_PERIOD_LSB +: 2];
        wd_enable <= wdog_new[WDC_ENABLE];
      end
      if (wd_int_pulse) begin
        wd_int_flag <= 1'b1;
      end else if (wd_int_clr || rs_active) begin
        wd_int_flag <= 1'b0;
      end
      if (wd_reset_pulse) begin
        wd_rst_flag <= 1'b1;
      end else if (wd_rst_clr) begin
        wd_rst_flag <= 1'b0;
      end
      if (power_loss_clr) begin
        power_loss <= 1'b0;
      end
    end
  end

  // Oscillator control returns to 0002h and debug bits clear only on power-on reset.
  always_ff @(posedge CORE_CLK_I) begin
    if (por_clr) begin
      osc_ctrl <= OSC_CTRL_RESET;
      dbg_rw <= '0;
      dbg_wo <= '0;
    end else begin
      if (wr_osc) begin
        osc_ctrl <= merge16(osc_ctrl, wdat, bus.sel);
      end
      if (wr_dbg) begin
        dbg_rw <= dbg_new[DBG_RW_LSB +: DBG_FIELD_W];
        dbg_wo <= dbg_new[DBG_FIELD_W-1:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      CLK_SEL_RC_O <= 1'b1;
    end else begin
      CLK_SEL_RC_O <= por_clr | osc_ctrl[OSC_RC_SELECT];
    end
  end

  // Sticky events; a new event outweighs a write-one clear in one cycle.
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      irq_status <= '0;
      irq_mask <= '0;
      IRQ_O <= 1'b0;
    end else if (rs_por) begin
      irq_status <= irq_set;
      irq_mask <= '0;
      IRQ_O <= 1'b0;
    end else begin
      irq_status <= irq_set |
        (irq_status & ~(wr_stat ? w1[IRQ_W-1:0] : {IRQ_W{1'b0}}));
      if (wr_mask) begin
        irq_mask <= mask_new[IRQ_W-1:0];
      end
      IRQ_O <= |(irq_status & irq_mask);
    end
  end

  // Single-wait-state slave: ack one cycle after the strobe, for one cycle.
  // Unmapped offsets are acknowledged, read as zero and ignore writes.
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      WB_ACK_O <= req & ~WB_ACK_O;
      if (req && !WB_ACK_O) begin
        WB_DAT_O <= {16'h0000, rd_word};
      end
    end
  end

endmodule

// ---- hw/reset_stretch.sv ----
`timescale 1ns/10ps
module reset_stretch
  import rst_seq_pkg::*;
#(
  parameter int HOLD = RESET_HOLD_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire reset_src_t src_i,
  output logic active_o,
  output logic internal_o,
  output logic por_o
);

  logic [7:0] cnt;
  logic any_src;

  assign any_src = src_i.por | src_i.wd | src_i.ext;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
      active_o <= 1'b0;
      internal_o <= 1'b0;
      por_o <= 1'b0;
    end else if (any_src) begin
      cnt <= 8'(HOLD);
      active_o <= 1'b1;
      if (src_i.por || src_i.wd) begin
        internal_o <= 1'b1;
      end
      if (src_i.por) begin
        por_o <= 1'b1;
      end
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end else begin
      active_o <= 1'b0;
      internal_o <= 1'b0;
      por_o <= 1'b0;
    end
  end

endmodule

// ---- hw/rst_seq_pkg.sv ----
// How it works
// - Any active reset halts execution and holds the processor in reset.
// - The RC oscillator keeps running through every reset.
// - Power-on or watchdog reset drives the active-low reset pin low.
// - Each supply-rise report from the detector starts a power-on reset.
// - Power-on reset returns every register and circuit to its default; the code keeps bus ack/data and loads the new events into IRQ status.
// - Power-on reset sets the power-loss flag, bit 7 of watchdog control.
// - After power-on reset the clock source selection is the RC oscillator.
// - Leaving power-on reset loads the program counter with 8000h.
// - After a watchdog reset, fetching resumes at 8000h.
// - Pin held low keeps the device in reset; release restarts at 8000h.
// - Oscillator control loads 0002h on power-on only, kept otherwise.
// - Debug read/write bits are accessible only in debug mode, cleared by POR.
// - Debug write bits accept writes only in debug mode, cleared by POR.
// - Watchdog reset follows the interrupt timeout by 512 cycles unless cleared.
package rst_seq_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  localparam logic [ADDR_W-1:0] OFS_WDOG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OSC_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DEBUG = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RESET_STATE = 8'h14;

  localparam int WDC_PERIOD_LSB = 0;
  localparam int WDC_ENABLE = 2;
  localparam int WDC_KICK = 3;
  localparam int WDC_INT_FLAG = 4;
  localparam int WDC_RST_FLAG = 6;
  localparam int WDC_POWER_LOSS = 7;
  localparam logic [1:0] WD_PERIOD_RESET = 2'h0;
  localparam logic WD_ENABLE_RESET = 1'b0;

  localparam int OSC_RC_SELECT = 1;
  localparam logic [REG_W-1:0] OSC_CTRL_RESET = 16'h0002;

  localparam int DBG_FIELD_W = 8;
  localparam int DBG_RW_LSB = 8;

  localparam int IRQ_WD_INT = 0;
  localparam int IRQ_WD_RESET = 1;
  localparam int IRQ_EXT_RESET = 2;
  localparam int IRQ_POR = 3;
  localparam int IRQ_W = 4;

  localparam logic [REG_W-1:0] RESET_VECTOR = 16'h8000;

  localparam int WD_INT_EXP = 12;
  localparam int WD_EXP_STEP = 3;
  localparam int WD_COUNT_W = 24;
  localparam int WD_RESET_CYCLES = 512;

  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_HOLD_NS = 320;
  localparam int RESET_HOLD_CYCLES =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic por;
    logic wd;
    logic ext;
  } reset_src_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADDR_W-1:0] adr;
    logic [3:0] sel;
    logic [DATA_W-1:0] dat;
  } wb_req_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HOLD = 2'b01,
    ST_EXIT = 2'b11
  } seq_state_t;

endpackage

// ---- hw/watchdog_timer.sv ----
`timescale 1ns/10ps
module watchdog_timer
  import rst_seq_pkg::*;
#(
  parameter int EXP = WD_INT_EXP,
  parameter int CNT_W = WD_COUNT_W
) (
  input wire logic clk_i,
  input wire logic clear_i,
  input wire logic [1:0] period_i,
  input wire logic reset_en_i,
  input wire logic kick_i,
  input wire logic int_flag_i,
  output logic int_pulse_o,
  output logic reset_pulse_o
);

  logic [CNT_W-1:0] count;
  logic [9:0] rst_count;
  logic arming;
  logic [1:0] last_period;
  logic [CNT_W-1:0] limit;
  logic terminal;
  logic period_change;

  assign limit = CNT_W'((64'h1 << (EXP + WD_EXP_STEP * int'(period_i))) - 1);
  assign terminal = count == limit;
  // A period change restarts the count except while the reset countdown (arming) runs.
  assign period_change = !arming && (period_i != last_period);

  always_ff @(posedge clk_i) begin
    if (clear_i) begin
      count <= '0;
      rst_count <= '0;
      arming <= 1'b0;
      last_period <= WD_PERIOD_RESET;
      int_pulse_o <= 1'b0;
      reset_pulse_o <= 1'b0;
    end else begin
      int_pulse_o <= 1'b0;
      reset_pulse_o <= 1'b0;
      last_period <= period_i;
      if (kick_i || period_change) begin
        count <= '0;
      end else if (terminal) begin
        count <= '0;
        int_pulse_o <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
      if (kick_i) begin
        arming <= 1'b0;
      end else if (terminal && !arming) begin
        arming <= 1'b1;
        rst_count <= '0;
      end else if (arming) begin
        // The flag is set one cycle after the pulse, so skip the first look.
        if (rst_count != '0 && !int_flag_i) begin
          arming <= 1'b0;
        end else if (rst_count == 10'(WD_RESET_CYCLES - 1)) begin
          reset_pulse_o <= reset_en_i;
          arming <= 1'b0;
        end else begin
          rst_count <= rst_count + 1'b1;
        end
      end
    end
  end

endmodule

// ---- verification/ext_reset_model.sv ----
`timescale 1ns/10ps
module ext_reset_model (
  input wire logic pin_oe_i,
  input wire logic pin_o_i,
  input wire logic pull_i,
  output logic pin_n_o
);
  // The pin has a pull-up, so it reads high unless some party pulls it low.
  assign pin_n_o = !((pin_oe_i && !pin_o_i) || pull_i);
endmodule

// ---- verification/reset_source_sequencer_properties.sv ----
`timescale 1ns/10ps
module reset_source_sequencer_properties
  import rst_seq_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic POR_RISE_I,
  input wire logic RESET_N_PIN_I,
  input wire logic RESET_N_PIN_O,
  input wire logic RESET_N_PIN_OE_O,
  input wire logic CPU_HALT_O,
  input wire logic SYS_RESET_O,
  input wire logic POR_RESET_O,
  input wire logic PC_LOAD_O,
  input wire logic [REG_W-1:0] PC_VECTOR_O,
  input wire logic RC_OSC_EN_O,
  input wire logic CLK_SEL_RC_O,
  input wire logic IRQ_O,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O
);
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RESET_I);

  osc_run_a: assert property (RC_OSC_EN_O)
    else $error("oscillator enable dropped");
  pin_drive_a: assert property (RESET_N_PIN_OE_O |-> !RESET_N_PIN_O)
    else $error("reset pin driven high");
  por_start_a: assert property (POR_RISE_I |-> ##2 (POR_RESET_O && RESET_N_PIN_OE_O && CPU_HALT_O))
    else $error("supply rise did not start power-on reset");
  halt_reset_a: assert property (SYS_RESET_O |-> CPU_HALT_O)
    else $error("reset active without halt");
  ext_pin_a: assert property ((!RESET_N_PIN_I && !RESET_N_PIN_OE_O) |-> ##2 SYS_RESET_O)
    else $error("external pin low did not reset");
  pin_hold_a: assert property ((CPU_HALT_O && !RESET_N_PIN_I) |=> CPU_HALT_O)
    else $error("left reset while pin low");
  exit_pulse_a: assert property (PC_LOAD_O |-> CPU_HALT_O ##1 (!PC_LOAD_O && !CPU_HALT_O))
    else $error("reset exit sequence wrong");
  exit_vector_a: assert property (PC_LOAD_O |-> PC_VECTOR_O == 16'h8000)
    else $error("wrong restart vector");
  rc_select_a: assert property (POR_RESET_O |-> CLK_SEL_RC_O)
    else $error("clock not on oscillator during power-on");
  bus_ack_a: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("bus answer timing wrong");

  cover property (POR_RESET_O);
  cover property (PC_LOAD_O);
  cover property (IRQ_O);
  cover property (!RESET_N_PIN_I && !RESET_N_PIN_OE_O);
endmodule

// ---- verification/reset_source_sequencer_tb.sv ----
`timescale 1ns/10ps
module reset_source_sequencer_tb;
  import rst_seq_pkg::*;
  logic clk = 0, rst = 1, por = 0, dbg = 0, pull = 0;
  logic cyc = 0, stb = 0, we = 0;
  logic [ADDR_W-1:0] adr = '0;
  logic [3:0] sel = '0;
  logic [DATA_W-1:0] wdat = '0, rd;
  wire pin_n, pin_o, pin_oe, halt, sys, porst, pcl, osc, csel, irq, ack;
  wire [REG_W-1:0] vec;
  wire [DATA_W-1:0] rdat;
  int n_fail = 0, checks = 0;

  always #10 clk = ~clk;

  // Short watchdog and stretch counts keep the run brief.
  reset_source_sequencer #(.WD_EXP(4), .HOLD(2)) reset_source_sequencer_i (
    .CORE_CLK_I(clk), .RESET_I(rst), .POR_RISE_I(por), .DEBUG_MODE_I(dbg),
    .RESET_N_PIN_I(pin_n), .RESET_N_PIN_O(pin_o), .RESET_N_PIN_OE_O(pin_oe),
    .CPU_HALT_O(halt), .SYS_RESET_O(sys), .POR_RESET_O(porst),
    .PC_LOAD_O(pcl), .PC_VECTOR_O(vec), .RC_OSC_EN_O(osc),
    .CLK_SEL_RC_O(csel), .IRQ_O(irq), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack));
  ext_reset_model ext_reset_model_i (.pin_oe_i(pin_oe), .pin_o_i(pin_o),
    .pull_i(pull), .pin_n_o(pin_n));

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h3;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    cyc <= 0;
    stb <= 0;
    check("bus answer", n < 50, 1);
  endtask

  task automatic wait_exit(input string what);
    int n;
    n = 0;
    while (pcl !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check(what, n < 200, 1);
    check("vector", vec, 16'h8000);
    @(posedge clk);
    #1;
    check("halt after exit", halt, 0);
  endtask

  task automatic t_defaults;
    bus(0, OFS_OSC_CTRL, 0);
    check("osc ctrl", rd, 32'h2);
    check("rc select", csel, 1);
    check("osc enable", osc, 1);
    bus(0, 8'h40, 0);
    check("unmapped", rd, 0);
  endtask

  task automatic t_debug;
    dbg <= 1;
    bus(1, OFS_DEBUG, 32'h5aa5);
    bus(0, OFS_DEBUG, 0);
    check("debug rw", rd, 32'h5aa5);
    dbg <= 0;
    bus(1, OFS_DEBUG, 0);
    dbg <= 1;
    bus(0, OFS_DEBUG, 0);
    check("debug locked", rd, 32'h5aa5);
    dbg <= 0;
    bus(0, OFS_DEBUG, 0);
    check("debug hidden", rd, 32'ha5);
    dbg <= 1;
  endtask

  task automatic t_por;
    bus(1, OFS_OSC_CTRL, 0);
    @(posedge clk);
    por <= 1;
    @(posedge clk);
    por <= 0;
    repeat (2) @(posedge clk);
    #1;
    check("por phase", porst, 1);
    check("pin low", pin_n, 0);
    check("halt", halt, 1);
    check("osc in reset", osc, 1);
    wait_exit("por exit");
    check("rc select", csel, 1);
    bus(0, OFS_WDOG_CTRL, 0);
    check("power loss", rd[7], 1);
    bus(0, OFS_OSC_CTRL, 0);
    check("osc ctrl por", rd, 32'h2);
    bus(0, OFS_DEBUG, 0);
    check("debug cleared", rd, 0);
    bus(1, OFS_WDOG_CTRL, 32'h80);
    bus(0, OFS_WDOG_CTRL, 0);
    check("power loss clear", rd[7], 0);
  endtask

  task automatic t_ext;
    bus(1, OFS_OSC_CTRL, 0);
    bus(1, OFS_IRQ_STATUS, 32'hf);
    @(posedge clk);
    pull <= 1;
    repeat (4) @(posedge clk);
    #1;
    check("ext reset", sys, 1);
    check("ext no drive", pin_oe, 0);
    @(posedge clk);
    pull <= 0;
    wait_exit("ext exit");
    bus(0, OFS_OSC_CTRL, 0);
    check("osc ctrl kept", rd, 0);
    check("irq masked", irq, 0);
    bus(1, OFS_IRQ_MASK, 32'h4);
    repeat (3) @(posedge clk);
    check("irq raised", irq, 1);
    bus(1, OFS_IRQ_STATUS, 32'h4);
    repeat (3) @(posedge clk);
    check("irq cleared", irq, 0);
  endtask

  task automatic t_wdog;
    int n;
    int m;
    n = 0;
    m = 0;
    // Kick and clear first, so the timeout phase is known before unmasking.
    bus(1, OFS_WDOG_CTRL, 32'h1c);
    bus(1, OFS_IRQ_STATUS, 32'h1);
    bus(1, OFS_IRQ_MASK, 32'h1);
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    while (pin_oe !== 1'b1 && m < 1000) begin
      @(posedge clk);
      m++;
    end
    // The interrupt output and the pin drive each add a cycle or two.
    check("wd delay", m >= 508 && m <= 518, 1);
    check("wd pin low", pin_n, 0);
    wait_exit("wd exit");
    bus(0, OFS_WDOG_CTRL, 0);
    check("wd flags", rd[7:6], 2'h1);
    // A service routine that keeps clearing the flag must prevent the reset.
    repeat (48) begin
      repeat (10) @(posedge clk);
      bus(1, OFS_WDOG_CTRL, 32'h54);
    end
    bus(0, OFS_WDOG_CTRL, 0);
    check("wd serviced", rd[6], 0);
    bus(1, OFS_WDOG_CTRL, 0);
  endtask

  task automatic conclude;
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    t_defaults();
    t_debug();
    t_por();
    t_ext();
    t_wdog();
    conclude();
  end

  initial begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule

bind reset_source_sequencer reset_source_sequencer_properties props_i (
  .CORE_CLK_I, .RESET_I, .POR_RISE_I, .RESET_N_PIN_I, .RESET_N_PIN_O,
  .RESET_N_PIN_OE_O, .CPU_HALT_O, .SYS_RESET_O, .POR_RESET_O, .PC_LOAD_O,
  .PC_VECTOR_O, .RC_OSC_EN_O, .CLK_SEL_RC_O, .IRQ_O, .WB_CYC_I, .WB_STB_I,
  .WB_ACK_O);
